// >>> aio_gp_pins.sv
// Pin logic of one 8-bit general-purpose port: input synchroniser, pad drive, capture feed.
// Assumes its control word comes from registers on the same clock.
`timescale 1ns/100ps
module aio_gp_pins
    import aio_pkg::*;
#(
    parameter logic [7:0] CAP_MASK = AIO_ALL_CAP,
    parameter logic [7:0] OUT_MASK = AIO_NONE
) (
    // Clock, reset, enable.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // Register side.
    input  wire aio_gp_ctl_s ctl,
    output logic [7:0]       rd_data,
    // Pads.
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe,
    // Timers.
    input  wire logic [7:0]  tmr_out,
    output logic [7:0]       cap_in
);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] cap;
    } aio_pin_st_s;

    aio_pin_st_s st_r;
    aio_pin_st_s st_nxt;
    logic [7:0]  drive_w;
    logic [7:0]  alt_out_w;

    // Pins selected for capture never drive, even with direction set, so a timer input cannot fight the pad.
    assign drive_w   = ctl.dir & ~(ctl.fs & CAP_MASK);
    assign alt_out_w = ctl.fs & OUT_MASK;

    // Next state: synchroniser, pad drive and capture feed.
    always_comb begin
        st_nxt     = st_r;
        st_nxt.s1  = pin_in;
        st_nxt.s2  = st_r.s1;
        st_nxt.oe  = drive_w;
        st_nxt.out = (ctl.dat & ~alt_out_w) | (tmr_out & alt_out_w);
        st_nxt.cap = st_r.s2 & ctl.ie & ctl.fs & CAP_MASK;
    end

    // State register; pads come out of reset undriven.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.out;
    assign pin_oe  = st_r.oe;
    assign cap_in  = st_r.cap;
    // Enabled bits read the pad, the others read back the latch.
    assign rd_data = (st_r.s2 & ctl.ie) | (ctl.dat & ~ctl.ie);

    oe_dir_a : assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) && $past(aresetn) |-> pin_oe == $past(drive_w))
        else $error("pad enable does not follow direction and select");

    out_port_a : assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) && $past(aresetn) && $past(ctl.dir[0]) && !$past(ctl.fs[0])
        |-> pin_out[0] == $past(ctl.dat[0]))
        else $error("port-mode output does not show the latch");

    tmr_out_a : assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) && $past(aresetn) && $past(alt_out_w[7])
        |-> pin_out[7] == $past(tmr_out[7]))
        else $error("timer output not routed to pad");

    cap_a : assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) && $past(aresetn) && !$past(ctl.fs[0]) |-> !cap_in[0])
        else $error("capture active while pin in port mode");

endmodule

// >>> aio_pins_model.sv
// Pad model for aio_ports: outside levels on analog and general pads.
// Assumes the bench drives ext_an and ext_gp as the outside world's levels.
`timescale 1ns/100ps
module aio_pins_model
    import aio_pkg::*;
(
    // Outside levels.
    input  wire logic [23:0] ext_an,
    input  wire logic [23:0] ext_gp,
    // Block side.
    input  wire logic [23:0] gp_pin_out,
    input  wire logic [23:0] gp_pin_oe,
    output logic [23:0]      analog_pin_in,
    output logic [23:0]      gp_pin_in
);
    // A driven pad wins over the outside level, bit by bit, so no contention is modelled.
    assign gp_pin_in     = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & ext_gp);
    assign analog_pin_in = ext_an;
endmodule

// >>> aio_pkg.sv
// Constants, carrier types and address decoding for the analog and timer I/O port block.
// Assumes an AXI4-Lite master with 32-bit data; every register is one word, data in bits 7:0.
package aio_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [31:0] AIO_IDX_AN1_PINS = 32'hffff_f080;
    localparam logic [31:0] AIO_IDX_AN1_IE   = 32'hffff_f08e;
    localparam logic [31:0] AIO_IDX_AN2_PINS = 32'hffff_f090;
    localparam logic [31:0] AIO_IDX_AN2_IE   = 32'hffff_f09e;
    localparam logic [31:0] AIO_IDX_AN3_PINS = 32'hffff_f0a0;
    localparam logic [31:0] AIO_IDX_AN3_IE   = 32'hffff_f0ae;
    localparam logic [31:0] AIO_IDX_GP1_DAT  = 32'hffff_f0b0;
    localparam logic [31:0] AIO_IDX_GP1_DIR  = 32'hffff_f0b1;
    localparam logic [31:0] AIO_IDX_GP1_FS   = 32'hffff_f0b2;
    localparam logic [31:0] AIO_IDX_GP1_IE   = 32'hffff_f0be;
    localparam logic [31:0] AIO_IDX_GP2_DAT  = 32'hffff_f0c0;
    localparam logic [31:0] AIO_IDX_GP2_DIR  = 32'hffff_f0c1;
    localparam logic [31:0] AIO_IDX_GP2_FS   = 32'hffff_f0c2;
    localparam logic [31:0] AIO_IDX_GP2_IE   = 32'hffff_f0ce;
    localparam logic [31:0] AIO_IDX_GP3_DAT  = 32'hffff_f0d0;
    localparam logic [31:0] AIO_IDX_GP3_DIR  = 32'hffff_f0d1;
    localparam logic [31:0] AIO_IDX_GP3_FS   = 32'hffff_f0d2;
    localparam logic [31:0] AIO_IDX_GP3_IE   = 32'hffff_f0de;

    // ------------------------------------------------------------------
    // Reset values, pin roles and bus answers.
    // ------------------------------------------------------------------
    localparam logic [7:0] AIO_IE_RST    = 8'h00;
    localparam logic [7:0] AIO_LATCH_RST = 8'h00;
    localparam logic [7:0] AIO_DIR_RST   = 8'h00;
    localparam logic [7:0] AIO_FS_RST    = 8'h00;
    localparam logic [7:0] AIO_GP3_CAP   = 8'h3f;
    localparam logic [7:0] AIO_GP3_OUT   = 8'hc0;
    localparam logic [7:0] AIO_ALL_CAP   = 8'hff;
    localparam logic [7:0] AIO_NONE      = 8'h00;
    localparam logic [1:0] AIO_OKAY      = 2'h0;
    localparam logic [1:0] AIO_SLVERR    = 2'h2;
    localparam logic [1:0] AIO_DECERR    = 2'h3;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        AIO_K_NONE = 3'b000,
        AIO_K_APIN = 3'b001,
        AIO_K_AIE  = 3'b010,
        AIO_K_GDAT = 3'b011,
        AIO_K_GDIR = 3'b100,
        AIO_K_GFS  = 3'b101,
        AIO_K_GIE  = 3'b110
    } aio_kind_e;

    typedef struct packed {
        aio_kind_e  kind;
        logic [1:0] port;
    } aio_sel_s;

    typedef struct packed {
        logic [7:0] dat;
        logic [7:0] dir;
        logic [7:0] fs;
        logic [7:0] ie;
    } aio_gp_ctl_s;

    // Maps a byte address to register kind and port number; low two bits ignored.
    function automatic aio_sel_s aio_decode(input logic [31:0] addr);
        aio_sel_s s;
        s = '{kind: AIO_K_NONE, port: 2'h0};
        case (addr[31:2])
            AIO_IDX_AN1_PINS[29:0]: s = '{AIO_K_APIN, 2'h0};
            AIO_IDX_AN2_PINS[29:0]: s = '{AIO_K_APIN, 2'h1};
            AIO_IDX_AN3_PINS[29:0]: s = '{AIO_K_APIN, 2'h2};
            AIO_IDX_AN1_IE[29:0]:   s = '{AIO_K_AIE,  2'h0};
            AIO_IDX_AN2_IE[29:0]:   s = '{AIO_K_AIE,  2'h1};
            AIO_IDX_AN3_IE[29:0]:   s = '{AIO_K_AIE,  2'h2};
            AIO_IDX_GP1_DAT[29:0]:  s = '{AIO_K_GDAT, 2'h0};
            AIO_IDX_GP2_DAT[29:0]:  s = '{AIO_K_GDAT, 2'h1};
            AIO_IDX_GP3_DAT[29:0]:  s = '{AIO_K_GDAT, 2'h2};
            AIO_IDX_GP1_DIR[29:0]:  s = '{AIO_K_GDIR, 2'h0};
            AIO_IDX_GP2_DIR[29:0]:  s = '{AIO_K_GDIR, 2'h1};
            AIO_IDX_GP3_DIR[29:0]:  s = '{AIO_K_GDIR, 2'h2};
            AIO_IDX_GP1_FS[29:0]:   s = '{AIO_K_GFS,  2'h0};
            AIO_IDX_GP2_FS[29:0]:   s = '{AIO_K_GFS,  2'h1};
            AIO_IDX_GP3_FS[29:0]:   s = '{AIO_K_GFS,  2'h2};
            AIO_IDX_GP1_IE[29:0]:   s = '{AIO_K_GIE,  2'h0};
            AIO_IDX_GP2_IE[29:0]:   s = '{AIO_K_GIE,  2'h1};
            AIO_IDX_GP3_IE[29:0]:   s = '{AIO_K_GIE,  2'h2};
            default:                s = '{AIO_K_NONE, 2'h0};
        endcase
        return s;
    endfunction

endpackage

// >>> aio_ports.sv
// Top of the analog and timer I/O ports: AXI4-Lite register slave, three analog input
// ports and three general-purpose ports with timer alternate functions.
// Assumes pads and timers sit outside; analog pins arrive asynchronous to aclk.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module aio_ports
    import aio_pkg::*;
(
    // Clock, reset, enable.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,

    // AXI4-Lite write address.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,

    // AXI4-Lite write data.
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,

    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,

    // AXI4-Lite read address.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,

    // AXI4-Lite read data.
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,

    // Analog port pads, three ports of eight.
    input  wire logic [23:0] analog_pin_in,

    // General-purpose port pads, three ports of eight.
    input  wire logic [23:0] gp_pin_in,
    output logic [23:0]      gp_pin_out,
    output logic [23:0]      gp_pin_oe,

    // Timer connections.
    output logic [21:0]      timer_capture_input,
    input  wire logic [1:0]  timer_output
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------

    // Index 0..2 of ie holds the analog ports, 3..5 the general ports.
    typedef struct packed {
        logic            aw_got;
        logic [31:0]     awaddr;
        logic            w_got;
        logic [7:0]      wdata;
        logic            wen;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [7:0]      rdata;
        logic [1:0]      rresp;
        logic [2:0][7:0] an_s1;
        logic [2:0][7:0] an_s2;
        logic [5:0][7:0] ie;
        logic [2:0][7:0] dat;
        logic [2:0][7:0] dir;
        logic [2:0][7:0] fs;
    } aio_st_s;

    aio_st_s         st_r;
    aio_st_s         st_nxt;
    aio_sel_s        wsel_w;
    aio_sel_s        rsel_w;
    logic [2:0][7:0] gp_rd_w;
    logic [2:0][7:0] tmr_w;
    logic [2:0][7:0] cap_w;
    logic [7:0]      rval_w;
    logic [1:0]      rresp_w;
    logic [7:0]      an1_lvl_w;

    // ------------------------------------------------------------------
    // Handshake outputs.
    // ------------------------------------------------------------------

    // Ready drops with ce so nothing is taken while the state is frozen.
    assign s_axi_awready = ce && !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = ce && !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = ce && !st_r.rvalid;

    // Response outputs come straight from the state register.
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp  = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata  = {24'h00_0000, st_r.rdata};
    assign s_axi_rresp  = st_r.rresp;

    // ------------------------------------------------------------------
    // Decode and read mux.
    // ------------------------------------------------------------------

    // The write decodes its held address; the read decodes the live one at the handshake.
    assign wsel_w = aio_decode(st_r.awaddr);
    assign rsel_w = aio_decode(s_axi_araddr);

    // Analog data reads zero on bits whose digital input is still disabled.
    assign an1_lvl_w = st_r.an_s2[0] & st_r.ie[0];

    // Read value for the address offered on the read channel.
    always_comb begin
        rval_w  = 8'h00;
        rresp_w = AIO_OKAY;
        case (rsel_w.kind)
            AIO_K_APIN: begin
                rval_w = st_r.an_s2[rsel_w.port] & st_r.ie[rsel_w.port];
            end
            AIO_K_AIE: begin
                rval_w = st_r.ie[rsel_w.port];
            end
            AIO_K_GDAT: begin
                rval_w = gp_rd_w[rsel_w.port];
            end
            AIO_K_GDIR: begin
                rval_w = st_r.dir[rsel_w.port];
            end
            AIO_K_GFS: begin
                rval_w = st_r.fs[rsel_w.port];
            end
            AIO_K_GIE: begin
                rval_w = st_r.ie[3'(rsel_w.port) + 3'd3];
            end
            default: begin
                rresp_w = AIO_DECERR;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------

    // Address and data are latched independently, so either may come first.
    always_comb begin
        st_nxt       = st_r;
        // Analog pads pass two flops; only the second one is ever read.
        st_nxt.an_s1 = analog_pin_in;
        st_nxt.an_s2 = st_r.an_s1;

        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wen   = s_axi_wstrb[0];
        end

        // Commit a write once both halves are held; byte lane 0 carries the data.
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = AIO_OKAY;
            case (wsel_w.kind)
                AIO_K_APIN: begin
                    st_nxt.bresp = AIO_SLVERR;
                end
                AIO_K_AIE: begin
                    if (st_r.wen) begin
                        st_nxt.ie[wsel_w.port] = st_r.wdata;
                    end
                end
                AIO_K_GDAT: begin
                    if (st_r.wen) begin
                        st_nxt.dat[wsel_w.port] = st_r.wdata;
                    end
                end
                AIO_K_GDIR: begin
                    if (st_r.wen) begin
                        st_nxt.dir[wsel_w.port] = st_r.wdata;
                    end
                end
                AIO_K_GFS: begin
                    if (st_r.wen) begin
                        st_nxt.fs[wsel_w.port] = st_r.wdata;
                    end
                end
                AIO_K_GIE: begin
                    if (st_r.wen) begin
                        st_nxt.ie[3'(wsel_w.port) + 3'd3] = st_r.wdata;
                    end
                end
                default: begin
                    st_nxt.bresp = AIO_DECERR;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read: answer one cycle after the address is taken.
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rval_w;
            st_nxt.rresp  = rresp_w;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    // Every input enable resets to zero, so no digital input runs until software asks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r     <= '0;
            st_r.ie  <= {6{AIO_IE_RST}};
            st_r.dat <= {3{AIO_LATCH_RST}};
            st_r.dir <= {3{AIO_DIR_RST}};
            st_r.fs  <= {3{AIO_FS_RST}};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // General-purpose port pins.
    // ------------------------------------------------------------------

    assign tmr_w[0] = 8'h00;
    assign tmr_w[1] = 8'h00;
    assign tmr_w[2] = {timer_output, 6'h00};

    // Ports one and two feed capture inputs on every pin; port three splits in and out.
    genvar g;
    for (g = 0; g < 3; g++) begin : gp
        aio_gp_pins #(
            .CAP_MASK (g == 2 ? AIO_GP3_CAP : AIO_ALL_CAP),
            .OUT_MASK (g == 2 ? AIO_GP3_OUT : AIO_NONE)
        ) u_pins (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .ctl     ('{dat: st_r.dat[g], dir: st_r.dir[g],
                        fs: st_r.fs[g], ie: st_r.ie[g + 3]}),
            .rd_data (gp_rd_w[g]),
            .pin_in  (gp_pin_in[g*8 +: 8]),
            .pin_out (gp_pin_out[g*8 +: 8]),
            .pin_oe  (gp_pin_oe[g*8 +: 8]),
            .tmr_out (tmr_w[g]),
            .cap_in  (cap_w[g])
        );
    end

    // Ports one and two fill bits 15:0; port three adds its six capture pins above.
    assign timer_capture_input = {cap_w[2][5:0], cap_w[1], cap_w[0]};

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------

    sequence aw_w_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence ro_commit_s;
        ce && st_r.aw_got && st_r.w_got
            && st_r.awaddr[31:2] == AIO_IDX_AN1_PINS[29:0];
    endsequence

    sequence an1_read_s;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr[31:2] == AIO_IDX_AN1_PINS[29:0];
    endsequence

    ie_reset_a : assert property (@(posedge aclk)
        $rose(aresetn) |-> st_r.ie == '0 && !s_axi_rvalid)
        else $error("input enables not cleared by reset");

    gp_reset_a : assert property (@(posedge aclk)
        $rose(aresetn) |-> st_r.dat == '0 && st_r.dir == '0 && st_r.fs == '0 ##1 gp_pin_oe == '0)
        else $error("general port not cleared by reset");

    an_read_a : assert property (@(posedge aclk) disable iff (!aresetn)
        an1_read_s |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(an1_lvl_w)})
        else $error("analog pin read returned wrong level");

    ro_write_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ro_commit_s |=> s_axi_bvalid && s_axi_bresp == AIO_SLVERR && $stable(st_r.ie))
        else $error("write to read-only pin register not refused");

    wr_resp_a : assert property (@(posedge aclk) disable iff (!aresetn)
        aw_w_take_s ##1 ce |=> s_axi_bvalid)
        else $error("write response not given two cycles after taking");

    // ------------------------------------------------------------------
    // Refusals and clock enable.
    // ------------------------------------------------------------------

    // A read whose address decodes to no register.
    sequence bad_read_s;
        s_axi_arvalid && s_axi_arready && rsel_w.kind == AIO_K_NONE;
    endsequence

    // A write commit whose byte lane 0 strobe was low.
    sequence masked_commit_s;
        ce && st_r.aw_got && st_r.w_got && !st_r.wen;
    endsequence

    // Unmapped reads still complete, so a stray pointer cannot hang the master.
    dec_read_a : assert property (@(posedge aclk) disable iff (!aresetn)
        bad_read_s |=> s_axi_rvalid && s_axi_rresp == AIO_DECERR
            && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused with decode error");

    // A write with byte lane 0 off is answered but leaves every register alone.
    masked_wr_a : assert property (@(posedge aclk) disable iff (!aresetn)
        masked_commit_s |=> s_axi_bvalid
            && $stable(st_r.dat) && $stable(st_r.dir)
            && $stable(st_r.fs) && $stable(st_r.ie))
        else $error("masked write changed a register");

    // Bits of the first analog port read zero while all eight of its digital inputs are disabled.
    an_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
        an1_read_s && st_r.ie[0] == 8'h00
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("disabled analog input read back a level");

    // With the enable low the pads and the bus answers hold, whatever the inputs do.
    ce_freeze_a : assert property (@(posedge aclk) disable iff (!aresetn)
        !ce |=> $stable(gp_pin_oe) && $stable(gp_pin_out) && $stable(s_axi_rvalid)
            && $stable(s_axi_bvalid) && $stable(timer_capture_input))
        else $error("state moved while clock enable was low");

endmodule

// >>> aio_ports_tb.sv
// Bench for aio_ports: AXI4-Lite master tasks and a bench model of registers and pads.
// Assumes aio_pins_model stands for the pads and timer outputs come from the bench.
`timescale 1ns/100ps
module aio_ports_tb;
    import aio_pkg::*;
    logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
    logic [23:0] an_in, gp_in, gp_out, gp_oe, ext_an, ext_gp;
    logic [21:0] cap;
    logic [7:0]  rs, ie, dt, dr, fs, eo, eq, lv, er, ec, ex, a;
    logic [1:0]  bresp, rresp, tmo, r;
    logic [3:0]  ws;
    int          fail_count, n_checks;
    logic [31:0] ai[3] = '{AIO_IDX_AN1_IE, AIO_IDX_AN2_IE, AIO_IDX_AN3_IE};
    logic [31:0] ap[3] = '{AIO_IDX_AN1_PINS, AIO_IDX_AN2_PINS, AIO_IDX_AN3_PINS};
    logic [31:0] gr[3][4] = '{'{AIO_IDX_GP1_DAT, AIO_IDX_GP1_DIR, AIO_IDX_GP1_FS, AIO_IDX_GP1_IE},
                              '{AIO_IDX_GP2_DAT, AIO_IDX_GP2_DIR, AIO_IDX_GP2_FS, AIO_IDX_GP2_IE},
                              '{AIO_IDX_GP3_DAT, AIO_IDX_GP3_DIR, AIO_IDX_GP3_FS, AIO_IDX_GP3_IE}};

    aio_ports uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(ws),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .analog_pin_in(an_in), .gp_pin_in(gp_in), .gp_pin_out(gp_out), .gp_pin_oe(gp_oe),
        .timer_capture_input(cap), .timer_output(tmo));
    aio_pins_model pads (.ext_an(ext_an), .ext_gp(ext_gp), .gp_pin_out(gp_out),
        .gp_pin_oe(gp_oe), .analog_pin_in(an_in), .gp_pin_in(gp_in));

    // Free-running 10 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // --------------------------------------------------------------
    // Verdict, comparison and bus tasks.
    // --------------------------------------------------------------
    task automatic results();
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    function automatic logic [7:0] nx();
        rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
        return rs;
    endfunction
    // Handshakes are judged at the falling edge, so the rising edge never races the slave.
    task automatic wr(input logic [31:0] ix, input logic [7:0] d);
        logic ha, hw, hb;
        awaddr <= {ix[29:0], 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) begin
                bready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        fail_count++;
        results();
    endtask
    task automatic rd(input logic [31:0] ix);
        logic ha, hr;
        araddr <= {ix[29:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            rd_v = rdata;
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hr) begin
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        fail_count++;
        results();
    endtask

    // Main sequence: reset values, random port traffic, refusals, a second reset.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, ext_gp, tmo} = '0;
        ext_an = 24'hff_ffff;
        ce = 1'b1;
        ws = 4'hf;
        {fail_count, n_checks} = '0;
        rs = 8'h54;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            rd(ai[p]);
            chk("analog enable", 0, rd_v);
            rd(ap[p]);
            chk("pins disabled", 0, rd_v);
            for (int k = 0; k < 4; k++) begin
                rd(gr[p][k]);
                chk("gp register", 0, rd_v);
            end
            for (int it = 0; it < 4; it++) begin
                {ie, dt, dr, fs, ex, a} = {nx(), nx(), nx(), nx(), nx(), nx()};
                ext_gp[8*p+:8] <= ex;
                ext_an[8*p+:8] <= a;
                tmo <= a[7:6];
                wr(ai[p], ie);
                wr(ap[p], dt);
                chk("pins write", AIO_SLVERR, r);
                wr(gr[p][0], dt);
                wr(gr[p][1], dr);
                wr(gr[p][2], fs);
                wr(gr[p][3], ie);
                repeat (5) @(posedge aclk);
                for (int b = 0; b < 8; b++) begin
                    eo[b] = dr[b] & ~(fs[b] & (p < 2 || b < 6));
                    eq[b] = (p == 2 && b > 5 && fs[b]) ? a[b] : dt[b];
                    lv[b] = eo[b] ? eq[b] : ex[b];
                    er[b] = ie[b] ? lv[b] : dt[b];
                    ec[b] = lv[b] & ie[b] & fs[b] & (p < 2 || b < 6);
                end
                chk("pad out", eq, gp_out[8*p+:8]);
                chk("pad enable", eo, gp_oe[8*p+:8]);
                chk("capture", ec, 8'({2'b00, cap} >> 8 * p));
                rd(gr[p][0]);
                chk("gp data", er, rd_v);
                rd(gr[p][1]);
                chk("direction", dr, rd_v);
                rd(ap[p]);
                chk("analog pins", a & ie, rd_v);
            end
        end
        ws <= 4'h0;
        wr(gr[2][1], ~dr);
        chk("masked resp", AIO_OKAY, r);
        ws <= 4'hf;
        rd(gr[2][1]);
        chk("masked write", dr, rd_v);
        ce <= 1'b0;
        tmo <= ~tmo;
        @(negedge aclk);
        chk("ready with ce low", 0, {awready, wready, arready});
        @(posedge aclk);
        ce <= 1'b1;
        rd(32'hffff_f0f0);
        chk("unmapped resp", AIO_DECERR, r);
        chk("unmapped data", 0, rd_v);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("pad enable after reset", 0, gp_oe);
        chk("pad out after reset", 0, gp_out);
        @(posedge aclk);
        rd(gr[2][2]);
        chk("select after reset", 0, rd_v);
        rd(ap[2]);
        chk("pins after reset", 0, rd_v);
        results();
    end
endmodule
